// file: design/otb_ack_timer.sv
// Acknowledge timeout counter for the bridge
`timescale 1ns/100ps
module otb_ack_timer
    import otb_pkg::*;
#(
    parameter int LIMIT = ACK_TIMEOUT_CYC
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic run, // Count while high
    input wire logic restart, // Start a fresh wait
    output logic expired // Wait reached its limit
);
    typedef struct packed {
        logic [15:0] cnt;
        logic expired;
    } otb_tmr_s;
    otb_tmr_s s_ff;
    otb_tmr_s nxt_s;

    assign expired = s_ff.expired;

    always_comb begin
        nxt_s = s_ff;
        if (!run || restart) begin
            nxt_s.cnt = 16'h0000;
            nxt_s.expired = 1'b0;
        end else if (s_ff.cnt == 16'(LIMIT - 1)) begin
            nxt_s.expired = 1'b1;
        end else begin
            nxt_s.cnt = s_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

// file: design/otb_bridge.sv
// Bridge end: backplane access decode, mapping space and onboard bus master
`timescale 1ns/100ps
module otb_bridge
    import otb_pkg::*;
#(
    parameter int ACK_LIMIT = ACK_TIMEOUT_CYC
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic [31:0] hrdata, // AHB read data
    output logic hresp, // AHB response, always OKAY
    input wire logic [4:0] geoSlot, // Board geographic slot
    input wire logic trigHalted, // Trigger machine stopped
    otb_if.bridge bus // Onboard transfer bus
);
    typedef struct packed {
        otb_br_e st;
        logic [23:0] vAddr;
        logic [5:0] am;
        logic [15:0] wData;
        logic goWr;
        logic busy;
        logic dtack;
        logic berr;
        logic noResp;
        logic timedOut;
        logic [15:0] rData;
        logic locCtrl;
        logic [3:0][15:0] mapEnt;
        logic [3:1][7:0] fifoCtl;
        logic [3:1] loaded;
        logic [6:0] csMask;
        logic [6:0] ackSeen;
        logic [11:2] obAddr;
        logic [15:0] obData;
        logic obOe;
        logic [7:1] csN;
        logic wrN;
        logic bufDir;
        logic bufOeN;
        logic hreadyout;
        logic [31:0] hrdata;
        logic apWr;
        logic [7:0] apAddr;
    } otb_br_s;
    otb_br_s s_ff;
    otb_br_s nxt_s;
    logic expired;
    logic tmrRun;
    logic tmrRestart;
    logic [4:0] slot;
    logic [6:0] chip;
    logic [1:0] muon;
    logic [6:0] regf;
    logic [3:0] pa;
    logic [15:0] ent;
    logic [6:0] ackNow;
    logic restricted;

    assign hreadyout = s_ff.hreadyout;
    assign hrdata = s_ff.hrdata;
    assign hresp = 1'b0;
    assign bus.addr = s_ff.obAddr;
    assign bus.brData = s_ff.obData;
    assign bus.brOe = s_ff.obOe;
    assign bus.csN = s_ff.csN;
    assign bus.wrN = s_ff.wrN;
    assign bus.bufDir = s_ff.bufDir;
    assign bus.bufOeN = s_ff.bufOeN;

    otb_ack_timer #(.LIMIT(ACK_LIMIT)) i_otb_ack_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(tmrRun),
        .restart(tmrRestart),
        .expired(expired)
    );

    // ====================================================================
    // Field extraction; block transfers take fields from a mapping entry
    always_comb begin
        slot = s_ff.vAddr[SLOT_LSB +: 5];
        pa = s_ff.vAddr[PA_LSB +: 4];
        ent = s_ff.mapEnt[s_ff.vAddr[WIN_LSB +: 2]];
        if (s_ff.am == AM_BLT) begin
            chip = ent[ENT_CHIP_LSB +: 7];
            muon = ent[ENT_MUON_LSB +: 2];
            regf = ent[6:0];
        end else begin
            chip = s_ff.vAddr[CHIP_LSB +: 7];
            muon = s_ff.vAddr[MUON_LSB +: 2];
            regf = s_ff.vAddr[REG_LSB +: 7];
        end
        restricted = (regf == RA_CORE_CFG) || (regf >= RA_LUT_FIRST && regf <= RA_LUT_LAST);
        ackNow = s_ff.ackSeen | (~bus.ackN & s_ff.csMask);
    end

    // ====================================================================
    // Register bus, decode and onboard cycle sequencing
    always_comb begin
        nxt_s = s_ff;
        nxt_s.hreadyout = 1'b1;
        nxt_s.apWr = 1'b0;
        tmrRun = (s_ff.st == BR_STROBE) || (s_ff.st == BR_RELEASE);
        tmrRestart = 1'b0;
        if (s_ff.apWr) begin
            unique case (s_ff.apAddr)
                OFS_ADDR: begin
                    nxt_s.vAddr = hwdata[23:0];
                    nxt_s.am = hwdata[29:24];
                end
                OFS_WDATA: nxt_s.wData = hwdata[15:0];
                OFS_CFG: nxt_s.locCtrl = hwdata[0];
                OFS_CTRL: begin
                    if (hwdata[CTL_GO] && !s_ff.busy) begin
                        nxt_s.goWr = hwdata[CTL_WR];
                        nxt_s.busy = 1'b1;
                        nxt_s.dtack = 1'b0;
                        nxt_s.berr = 1'b0;
                        nxt_s.noResp = 1'b0;
                        nxt_s.st = BR_DECODE;
                    end
                end
                default: ;
            endcase
        end
        if (hsel && htrans[1] && hready) begin
            nxt_s.apWr = hwrite;
            nxt_s.apAddr = haddr[7:0];
            unique case (haddr[7:0])
                OFS_ADDR: nxt_s.hrdata = {2'h0, s_ff.am, s_ff.vAddr};
                OFS_WDATA: nxt_s.hrdata = {16'h0000, s_ff.wData};
                OFS_CFG: nxt_s.hrdata = {31'h0, s_ff.locCtrl};
                OFS_STAT: nxt_s.hrdata = {s_ff.rData, 12'h000, s_ff.noResp, s_ff.berr, s_ff.dtack, s_ff.busy};
                default: nxt_s.hrdata = 32'h0000_0000;
            endcase
        end
        unique case (s_ff.st)
            BR_IDLE: ;
            BR_DECODE: begin
                nxt_s.st = BR_IDLE;
                nxt_s.busy = 1'b0;
                if (slot != geoSlot && slot != SLOT_MCAST) begin
                    nxt_s.noResp = 1'b1;
                end else if (s_ff.am == AM_PROG) begin
                    if (pa >= PA_CTL1 && pa <= PA_CTL3) begin
                        if (s_ff.goWr) begin
                            nxt_s.fifoCtl[pa[1:0]] = s_ff.wData[7:0];
                        end
                        nxt_s.rData = {s_ff.loaded[pa[1:0]], 7'h00, s_ff.fifoCtl[pa[1:0]]};
                        nxt_s.dtack = 1'b1;
                    end else if (pa >= PA_MAP && pa <= PA_ENT3) begin
                        if (s_ff.goWr) begin
                            nxt_s.mapEnt[pa[1:0]] = s_ff.wData;
                            if (pa != PA_MAP) begin
                                nxt_s.loaded[pa[1:0]] = 1'b1;
                            end
                        end
                        nxt_s.rData = s_ff.mapEnt[pa[1:0]];
                        nxt_s.dtack = 1'b1;
                    end else begin
                        nxt_s.berr = 1'b1;
                    end
                end else if (s_ff.am == AM_DATA || s_ff.am == AM_BLT) begin
                    if (chip == 7'h00 || (s_ff.am == AM_DATA && s_ff.vAddr[RSV_BIT])) begin
                        nxt_s.berr = 1'b1;
                    end else if (!s_ff.goWr && (((chip & (chip - 7'h01)) != 7'h00) || muon == MUON_ALL)) begin
                        nxt_s.berr = 1'b1;
                    end else if (s_ff.goWr && regf >= RA_STS_FIRST && regf <= RA_STS_LAST) begin
                        nxt_s.berr = 1'b1;
                    end else if (!s_ff.goWr && regf <= RA_ACT_LAST) begin
                        nxt_s.berr = 1'b1;
                    end else if (restricted && !(s_ff.locCtrl && trigHalted)) begin
                        nxt_s.berr = 1'b1;
                    end else begin
                        nxt_s.busy = 1'b1;
                        nxt_s.csMask = chip;
                        nxt_s.obAddr = {1'b0, muon, regf};
                        nxt_s.obData = s_ff.wData;
                        nxt_s.obOe = s_ff.goWr;
                        nxt_s.wrN = !s_ff.goWr;
                        nxt_s.bufDir = s_ff.goWr;
                        nxt_s.bufOeN = (chip & BUF_CHIPS) == 7'h00;
                        nxt_s.st = BR_SETUP;
                    end
                end else begin
                    nxt_s.noResp = 1'b1;
                end
            end
            BR_SETUP: begin
                nxt_s.csN = ~s_ff.csMask;
                nxt_s.ackSeen = 7'h00;
                nxt_s.timedOut = 1'b0;
                nxt_s.st = BR_STROBE;
                tmrRestart = 1'b1;
            end
            BR_STROBE: begin
                nxt_s.ackSeen = ackNow;
                if (ackNow == s_ff.csMask) begin
                    nxt_s.rData = bus.dataBus;
                    nxt_s.csN = 7'h7f;
                    nxt_s.st = BR_RELEASE;
                    tmrRestart = 1'b1;
                end else if (expired) begin
                    nxt_s.csN = 7'h7f;
                    nxt_s.timedOut = 1'b1;
                    nxt_s.st = BR_RELEASE;
                    tmrRestart = 1'b1;
                end
            end
            BR_RELEASE: begin
                if (((~bus.ackN & s_ff.csMask) == 7'h00) || expired) begin
                    nxt_s.obOe = 1'b0;
                    nxt_s.bufOeN = 1'b1;
                    nxt_s.wrN = 1'b1;
                    nxt_s.busy = 1'b0;
                    nxt_s.dtack = !s_ff.timedOut;
                    nxt_s.berr = s_ff.timedOut;
                    nxt_s.st = BR_IDLE;
                end
            end
            default: nxt_s.st = BR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.st <= BR_IDLE;
            s_ff.csN <= 7'h7f;
            s_ff.wrN <= 1'b1;
            s_ff.bufOeN <= 1'b1;
            s_ff.hreadyout <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

// file: design/otb_if.sv
// Onboard transfer bus wires shared by the bridge and up to seven targets
`timescale 1ns/100ps
interface otb_if;
    logic [11:2] addr;
    logic [15:0] brData;
    logic brOe;
    logic [7:1] csN;
    logic wrN;
    logic bufDir;
    logic bufOeN;
    wire [7:1] ackN;
    wire [7:1][15:0] tgData;
    wire [7:1] tgOe;
    logic [15:0] dataBus;

    // ====================================================================
    // Data bus resolution from the drive enables
    always_comb begin
        dataBus = brOe ? brData : 16'h0000;
        for (int i = 1; i <= 7; i++) begin
            if (tgOe[i]) begin
                dataBus = dataBus | tgData[i];
            end
        end
    end

    modport bridge (output addr, brData, brOe, csN, wrN, bufDir, bufOeN, input ackN, dataBus);
    modport target (input addr, csN, wrN, dataBus, output ackN, tgData, tgOe);
endinterface

// file: design/otb_pkg.sv
// Constants and types shared by the onboard transfer bus bridge, targets and timer
package otb_pkg;
    localparam int CHIPS = 7;
    localparam logic [5:0] AM_DATA = 6'h39;
    localparam logic [5:0] AM_PROG = 6'h3a;
    localparam logic [5:0] AM_BLT = 6'h3b;
    localparam logic [4:0] SLOT_MCAST = 5'h1e;
    localparam int SLOT_LSB = 19;
    localparam int CHIP_LSB = 12;
    localparam int RSV_BIT = 11;
    localparam int MUON_LSB = 9;
    localparam int REG_LSB = 2;
    localparam int WIN_LSB = 17;
    localparam int PA_LSB = 2;
    localparam int ENT_CHIP_LSB = 9;
    localparam int ENT_MUON_LSB = 7;
    localparam logic [3:0] PA_CTL1 = 4'h1;
    localparam logic [3:0] PA_CTL3 = 4'h3;
    localparam logic [3:0] PA_MAP = 4'h8;
    localparam logic [3:0] PA_ENT3 = 4'hb;
    localparam logic [6:0] RA_ACT_LAST = 7'h05;
    localparam logic [6:0] RA_STS_FIRST = 7'h0a;
    localparam logic [6:0] RA_STS_LAST = 7'h14;
    localparam logic [6:0] RA_CORE_CFG = 7'h46;
    localparam logic [6:0] RA_LUT_FIRST = 7'h60;
    localparam logic [6:0] RA_LUT_LAST = 7'h68;
    localparam logic [1:0] MUON_ALL = 2'h0;
    localparam logic [6:0] BUF_CHIPS = 7'h3f;
    localparam int CTL_LOADED_BIT = 15;
    localparam logic [7:0] OFS_ADDR = 8'h00;
    localparam logic [7:0] OFS_WDATA = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_CFG = 8'h10;
    localparam int CTL_GO = 0;
    localparam int CTL_WR = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_DTACK = 1;
    localparam int ST_BERR = 2;
    localparam int ST_NORESP = 3;
    localparam int ST_RDATA_LSB = 16;
    localparam int CLK_PERIOD_NS = 5;
    localparam int ACK_TIMEOUT_NS = 1000;
    localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int TGT_MEM_AW = 9;
    typedef enum logic [2:0] {BR_IDLE, BR_DECODE, BR_SETUP, BR_STROBE, BR_RELEASE} otb_br_e;
    typedef enum logic [1:0] {TG_IDLE, TG_FETCH, TG_DRIVE, TG_ACK} otb_tg_e;
endpackage

// file: design/otb_target.sv
// Target chip end of the onboard transfer bus with local register storage
`timescale 1ns/100ps
module otb_target
    import otb_pkg::*;
#(
    parameter int CHIP_IDX = 1
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    otb_if.target bus, // Onboard transfer bus
    input wire logic respondEn, // Answer selects when high
    output logic wrPulse, // One cycle per accepted write
    output logic [TGT_MEM_AW-1:0] wrAddr, // Location last written
    output logic [15:0] wrData // Word last written
);
    typedef struct packed {
        otb_tg_e st;
        logic ack;
        logic oe;
        logic [15:0] rdData;
        logic [TGT_MEM_AW-1:0] capAddr;
        logic wrPulse;
        logic [TGT_MEM_AW-1:0] wrAddr;
        logic [15:0] wrData;
    } otb_tg_s;
    otb_tg_s s_ff;
    otb_tg_s nxt_s;
    logic [15:0] mem [0:(1<<TGT_MEM_AW)-1];

    assign bus.ackN[CHIP_IDX] = ~s_ff.ack;
    assign bus.tgOe[CHIP_IDX] = s_ff.oe;
    assign bus.tgData[CHIP_IDX] = s_ff.rdData;
    assign wrPulse = s_ff.wrPulse;
    assign wrAddr = s_ff.wrAddr;
    assign wrData = s_ff.wrData;

    // ====================================================================
    // Handshake sequence
    always_comb begin
        nxt_s = s_ff;
        nxt_s.wrPulse = 1'b0;
        unique case (s_ff.st)
            TG_IDLE: begin
                if (!bus.csN[CHIP_IDX] && respondEn && !bus.addr[RSV_BIT]) begin
                    nxt_s.capAddr = bus.addr[10:2];
                    if (!bus.wrN) begin
                        nxt_s.wrAddr = bus.addr[10:2];
                        nxt_s.wrData = bus.dataBus;
                        nxt_s.wrPulse = 1'b1;
                        nxt_s.ack = 1'b1;
                        nxt_s.st = TG_ACK;
                    end else begin
                        nxt_s.st = TG_FETCH;
                    end
                end
            end
            TG_FETCH: begin
                nxt_s.rdData = mem[s_ff.capAddr];
                nxt_s.oe = 1'b1;
                nxt_s.st = TG_DRIVE;
            end
            TG_DRIVE: begin
                nxt_s.ack = 1'b1;
                nxt_s.st = TG_ACK;
            end
            TG_ACK: begin
                if (bus.csN[CHIP_IDX]) begin
                    nxt_s.ack = 1'b0;
                    nxt_s.oe = 1'b0;
                    nxt_s.st = TG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ====================================================================
    // Storage; muon field zero writes all three muon registers
    always_ff @(posedge clk_sys) begin
        if (s_ff.wrPulse) begin
            if (s_ff.wrAddr[8:7] == MUON_ALL) begin
                for (int m = 1; m <= 3; m++) begin
                    mem[{2'(m), s_ff.wrAddr[6:0]}] <= s_ff.wrData;
                end
            end else begin
                mem[s_ff.wrAddr] <= s_ff.wrData;
            end
        end
    end
endmodule

// file: testbench/onboard_transfer_bus_bridge_test.sv
// Bench for the bridge, seven onboard targets and the bus checker
`timescale 1ns/100ps
module onboard_transfer_bus_bridge_test
    import otb_pkg::*;
;
    localparam int LIM = 8;
    localparam logic [4:0] GS = 5'h05;
    localparam logic [2:0] OK = 3'h1;
    localparam logic [2:0] BE = 3'h2;
    localparam logic [2:0] NR = 3'h4;
    typedef struct packed {
        logic [5:0] am;
        logic [23:0] va;
        logic w;
        logic [15:0] wd;
        logic [2:0] code;
        logic [15:0] rd;
        logic [6:0] sel;
    } otb_row_s;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [4:0] geoSlot = GS;
    logic trigHalted = 1'b0;
    logic [7:1] respondEn = 7'h7f;
    logic [7:1] wrPulse;
    logic [7:1][8:0] wrAddr;
    logic [7:1][15:0] wrData;
    logic [6:0] seenCs;
    logic [9:0] seenAd;
    logic [31:0] d;
    otb_row_s rows[$];
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int nStored = 0;

    always #2.5 clk_sys = ~clk_sys;

    // ====================
    // Both ends of the bus
    otb_if bus ();
    otb_bridge #(.ACK_LIMIT(LIM)) i_otb_bridge (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .geoSlot(geoSlot), .trigHalted(trigHalted),
        .bus(bus.bridge));
    for (genvar g = 1; g <= 7; g++) begin : gTgt
        otb_target #(.CHIP_IDX(g)) i_otb_target (.clk_sys(clk_sys), .rst(rst), .bus(bus.target),
            .respondEn(respondEn[g]), .wrPulse(wrPulse[g]), .wrAddr(wrAddr[g]), .wrData(wrData[g]));
    end
    otb_monitor #(.ACK_LIMIT(LIM)) i_otb_monitor (.clk_sys(clk_sys), .rst(rst), .addr(bus.addr), .brOe(bus.brOe),
        .csN(bus.csN), .wrN(bus.wrN), .bufDir(bus.bufDir), .bufOeN(bus.bufOeN), .ackN(bus.ackN), .tgOe(bus.tgOe));

    // Remember which targets and address the last onboard cycle used; count target write pulses
    always @(posedge clk_sys) begin
        if (!rst) begin
            nStored <= nStored + $countones(wrPulse);
        end
        if (hsel && hwrite && haddr[7:0] == OFS_CTRL) begin
            seenCs <= 7'h00;
        end else if (bus.csN != 7'h7f) begin
            seenCs <= ~bus.csN;
            seenAd <= bus.addr;
        end
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ====================
    // Tasks
    function automatic logic [23:0] fa(input logic [4:0] s, input logic [6:0] c, input logic [1:0] m,
        input logic [6:0] r);
        return {s, c, 1'b0, m, r, 2'b00};
    endfunction

    function automatic logic [23:0] pa(input logic [3:0] p);
        return {GS, 13'h0, p, 2'b00};
    endfunction

    function automatic otb_row_s mk(input logic [5:0] am, input logic [23:0] va, input logic w,
        input logic [15:0] wd, input logic [2:0] code, input logic [15:0] rd, input logic [6:0] sel);
        return '{am, va, w, wd, code, rd, sel};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // For block transfers the rd field holds the expected onboard address
    task automatic run(input otb_row_s r);
        logic [31:0] st;
        int n;
        logic [8:0] ea;
        ea = (r.am == AM_BLT) ? r.rd[8:0] : r.va[10:2];
        ahb(1'b1, OFS_ADDR, {2'b00, r.am, r.va}, st);
        ahb(1'b1, OFS_WDATA, {16'h0, r.wd}, st);
        ahb(1'b1, OFS_CTRL, {30'h0, r.w, 1'b1}, st);
        n = 0;
        do begin
            ahb(1'b0, OFS_STAT, 32'h0, st);
            n++;
        end while (st[ST_BUSY] !== 1'b0 && n < 100);
        check({29'h0, st[ST_NORESP], st[ST_BERR], st[ST_DTACK]}, {29'h0, r.code});
        if (!r.w && r.code == OK) check({16'h0, st[31:16]}, {16'h0, r.rd});
        check({25'h0, seenCs}, {25'h0, r.sel});
        if (r.sel != 7'h00) check({22'h0, seenAd}, {22'h0, ((r.am == AM_BLT) ? r.rd[9:0] : r.va[11:2])});
        for (int i = 1; i <= 7; i++) begin
            if (r.w && r.code == OK && r.sel[i - 1]) check({7'h0, wrAddr[i], wrData[i]}, {7'h0, ea, r.wd});
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ====================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check({20'h0, bus.csN, bus.wrN, bus.bufOeN, bus.brOe, hreadyout, hresp}, 32'h00000ffa);
        ahb(1'b0, OFS_STAT, 32'h0, d);
        check(d, 32'h0);
        ahb(1'b1, 8'h14, 32'hffffffff, d);
        ahb(1'b0, 8'h14, 32'h0, d);
        check(d, 32'h0);
        rows = '{
            mk(AM_DATA, fa(GS, 7'h01, 2'h1, 7'h20), 1'b1, 16'h1234, OK, 16'h0, 7'h01),
            mk(AM_DATA, fa(GS, 7'h01, 2'h1, 7'h20), 1'b0, 16'h0, OK, 16'h1234, 7'h01),
            mk(AM_DATA, fa(5'h1e, 7'h41, 2'h2, 7'h21), 1'b1, 16'habcd, OK, 16'h0, 7'h41),
            mk(AM_DATA, fa(GS, 7'h40, 2'h2, 7'h21), 1'b0, 16'h0, OK, 16'habcd, 7'h40),
            mk(AM_DATA, fa(GS, 7'h02, 2'h0, 7'h22), 1'b1, 16'h5a5a, OK, 16'h0, 7'h02),
            mk(AM_DATA, fa(GS, 7'h02, 2'h3, 7'h22), 1'b0, 16'h0, OK, 16'h5a5a, 7'h02),
            mk(AM_DATA, fa(GS, 7'h03, 2'h1, 7'h20), 1'b0, 16'h0, BE, 16'h0, 7'h00),
            mk(AM_DATA, fa(GS, 7'h01, 2'h0, 7'h20), 1'b0, 16'h0, BE, 16'h0, 7'h00),
            mk(AM_DATA, fa(GS, 7'h00, 2'h1, 7'h20), 1'b1, 16'h1, BE, 16'h0, 7'h00),
            mk(AM_DATA, fa(GS, 7'h01, 2'h1, RA_STS_FIRST), 1'b1, 16'h1, BE, 16'h0, 7'h00),
            mk(AM_DATA, fa(GS, 7'h01, 2'h1, RA_ACT_LAST), 1'b0, 16'h0, BE, 16'h0, 7'h00),
            mk(AM_DATA, fa(GS, 7'h40, 2'h1, RA_CORE_CFG), 1'b1, 16'h1, BE, 16'h0, 7'h00),
            mk(AM_DATA, fa(5'h07, 7'h01, 2'h1, 7'h20), 1'b1, 16'h1, NR, 16'h0, 7'h00),
            mk(AM_PROG, pa(4'h9), 1'b1, {7'h04, 2'h1, 7'h23}, OK, 16'h0, 7'h00),
            mk(AM_PROG, pa(4'h9), 1'b0, 16'h0, OK, {7'h04, 2'h1, 7'h23}, 7'h00),
            mk(AM_PROG, pa(4'h1), 1'b1, 16'h005a, OK, 16'h0, 7'h00),
            mk(AM_PROG, pa(4'h1), 1'b0, 16'h0, OK, 16'h805a, 7'h00),
            mk(AM_PROG, pa(4'h4), 1'b0, 16'h0, BE, 16'h0, 7'h00),
            mk(AM_BLT, {GS, 2'h1, 17'h0}, 1'b1, 16'h7777, OK, 16'h00a3, 7'h04),
            mk(AM_DATA, fa(GS, 7'h04, 2'h1, 7'h23), 1'b0, 16'h0, OK, 16'h7777, 7'h04),
            mk(AM_PROG, pa(PA_MAP), 1'b1, {7'h01, 2'h2, 7'h24}, OK, 16'h0, 7'h00),
            mk(AM_BLT, {GS, 2'h0, 17'h1fffc}, 1'b1, 16'h2468, OK, 16'h0124, 7'h01)
        };
        foreach (rows[k]) run(rows[k]);
        ahb(1'b1, OFS_CFG, 32'h1, d);
        ahb(1'b0, OFS_CFG, 32'h0, d);
        check(d, 32'h1);
        trigHalted <= 1'b1;
        run(mk(AM_DATA, fa(GS, 7'h40, 2'h1, RA_CORE_CFG), 1'b1, 16'h0c0c, OK, 16'h0, 7'h40));
        trigHalted <= 1'b0;
        run(mk(AM_DATA, fa(GS, 7'h40, 2'h1, RA_LUT_LAST), 1'b1, 16'h0c0c, BE, 16'h0, 7'h00));
        respondEn <= 7'h6f;
        run(mk(AM_DATA, fa(GS, 7'h10, 2'h1, 7'h30), 1'b0, 16'h0, BE, 16'h0, 7'h10));
        run(mk(AM_DATA, fa(GS, 7'h11, 2'h1, 7'h30), 1'b1, 16'h3c3c, BE, 16'h0, 7'h11));
        respondEn <= 7'h7f;
        run(mk(AM_DATA, fa(GS, 7'h10, 2'h1, 7'h30), 1'b1, 16'h3c3c, OK, 16'h0, 7'h10));
        run(mk(AM_DATA, fa(GS, 7'h10, 2'h1, 7'h30), 1'b0, 16'h0, OK, 16'h3c3c, 7'h10));
        ahb(1'b0, OFS_ADDR, 32'h0, d);
        check(d, {2'b00, AM_DATA, fa(GS, 7'h10, 2'h1, 7'h30)});
        check(nStored, 32'h9);
        tally_and_finish();
    end
endmodule

// file: testbench/otb_monitor.sv
// Checker of the onboard transfer bus handshake between bridge and targets
`timescale 1ns/100ps
module otb_monitor
    import otb_pkg::*;
#(
    parameter int ACK_LIMIT = ACK_TIMEOUT_CYC
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [11:2] addr, // Word address
    input wire logic brOe, // Bridge drives data
    input wire logic [7:1] csN, // Chip selects
    input wire logic wrN, // Write line
    input wire logic bufDir, // Buffer direction
    input wire logic bufOeN, // Buffer enable
    input wire logic [7:1] ackN, // Acknowledges
    input wire logic [7:1] tgOe // Targets drive data
);
    // ====================
    // Strobe length counter
    logic [15:0] strobeCnt_ff;
    logic [15:0] nxt_strobeCnt;
    logic strobe;
    assign strobe = csN != 7'h7f;
    assign nxt_strobeCnt = strobe ? strobeCnt_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge clk_sys) begin
        strobeCnt_ff <= rst ? 16'h0000 : nxt_strobeCnt;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ====================
    // Assertions
    a_reserved_line_low: assert property (addr[11] == 1'b0)
        else $error("reserved line high");
    a_single_driver: assert property (!(brOe && tgOe != 7'h00))
        else $error("data driven twice");
    a_write_setup: assert property (strobe && !wrN |-> brOe && bufDir)
        else $error("write select without data");
    a_read_one_select: assert property (strobe && wrN |-> $onehot(~csN))
        else $error("read selects not one target");
    a_buffer_enable: assert property (strobe |-> bufOeN == (csN[6:1] == 6'h3f))
        else $error("buffer enable wrong");
    a_setup_stable: assert property (strobe |-> $stable(addr) && $stable(wrN))
        else $error("address moved under select");
    a_select_held: assert property (strobe && (~csN & ackN) != 7'h00
        && strobeCnt_ff < ACK_LIMIT - 2 |=> csN == $past(csN))
        else $error("select dropped before acks");
    a_timeout_bound: assert property (strobeCnt_ff <= ACK_LIMIT + 4)
        else $error("strobe outlived timeout");
    a_ack_after_select: assert property (((~ackN & $past(ackN)) & $past(csN)) == 7'h00)
        else $error("ack without select");
    a_read_data_first: assert property (wrN |-> ((~ackN & $past(ackN)) & ~$past(tgOe)) == 7'h00)
        else $error("read ack before data");
    a_ack_release: assert property ((~ackN & csN) != 7'h00 |=> (~ackN & $past(~ackN & csN)) == 7'h00)
        else $error("ack kept after select");
    c_multicast_write: cover property (strobe && !wrN && !$onehot(~csN));
    c_read_ack: cover property (strobe && wrN && ackN != 7'h7f);
    c_ack_timeout: cover property (strobeCnt_ff == ACK_LIMIT - 3);
endmodule
